// file: core/rcs_pkg.sv
// Constants for the relay card serial interface
package rcs_pkg;

  // Clock rates: crystal and the bus phase clock derived from it
  localparam int unsigned REF_CLK_HZ   = 40000000;
  localparam int unsigned CRYSTAL_HZ   = 7159090;
  localparam int unsigned BUS_DIVIDE   = 4;
  localparam int unsigned BUS_CLK_HZ   = CRYSTAL_HZ / BUS_DIVIDE;
  // Half period of the bus phase clock, rounded down, at least one cycle
  localparam int unsigned HALF_RAW     = REF_CLK_HZ / (2 * BUS_CLK_HZ);
  localparam int unsigned HALF_CYC     = (HALF_RAW < 1) ? 1 : HALF_RAW;
  localparam logic [4:0]  HALF_LAST    = 5'(HALF_CYC - 1);

  // Serial byte and counter layout
  localparam int unsigned BYTE_W       = 8;
  localparam logic [7:0]  CNT_PRESET   = 8'hff;
  localparam int unsigned FIFO_DEPTH   = 16;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0]  OFS_RELAY    = 8'h00;
  localparam logic [7:0]  OFS_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_IDENT    = 8'h60;
  localparam logic [7:0]  IDENT_MASK   = 8'hf0;

  // Control register fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_CLR_BIT = 8;
  localparam int unsigned CTRL_ADV_BIT = 9;
  localparam int unsigned CTRL_LAT_BIT = 10;
  localparam int unsigned NUM_CARDS    = 8;
  localparam logic [7:0]  SEL_RESET    = 8'hff;

  // Status register fields
  localparam int unsigned ST_ACT_BIT   = 0;
  localparam int unsigned ST_EMPTY_BIT = 1;
  localparam int unsigned ST_FULL_BIT  = 2;
  localparam int unsigned ST_IDV_BIT   = 3;
  localparam int unsigned ST_OEN_BIT   = 4;
  localparam int unsigned ST_LVL_LSB   = 8;

  // Card clock sequencer states
  typedef enum logic [1:0] {
    RCS_IDLE,
    RCS_ALIGN,
    RCS_HIGH,
    RCS_LOW
  } rcs_state_t;

endpackage : rcs_pkg

// file: core/rcs_top.sv
// Relay card serial interface: byte FIFO, card clock, shifters, registers
//
// Overview of operation
// R1: Card clock comes from the bus phase clock, crystal divided by four.
// R2: Relay data write loads the byte, presets bit counter, sets active flag.
// R3: Bus phase clock is gated out as card clock while active is high.
// R4: Counter drops active after eight card clock pulses; no more pulses.
// R5: Outgoing data shifts on inverted card clock, after the first cycle.
// R6: Card clock reaches all driver stages; each stage feeds the next.
// R7: Card ident memory holds model, settling time and relay position table.
// R8: Controller holds card select low for the whole ident transfer.
// R9: Address clear pulsed high once; card resets its 12-bit counter to zero.
// R10: Advance low steps the counter and loads ident shifter; held until settled.
// R11: Controller takes ident location one as the first location read.
// R12: Same card clock shifts eight ident bits back; one byte out per byte in.
// R13: Controller repeats advance and byte shift until all locations read.
// R14: Received ident byte is read in a sixteen-byte address window.
// R15: After all bytes, latch pulse moves shifted data to driver outputs.
// R16: Latch pulse is taken regardless of card select.
// R17: Driver outputs disabled from reset until first latch pulse falls.
// R18: Driver output low energizes its relay, high leaves it released.
// R19: Ident receiver shifts on the same card clock edges as outgoing byte; here it shifts on the rise, the outgoing byte on the fall.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.

// Byte FIFO between the bus writes and the serial sequencer
module rcs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // Fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic      [WIDTH-1:0]         out_data_o,
  // Fill level
  output logic      [$clog2(DEPTH):0]   level_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  always_comb begin
    level_o     = wr_ptr - rd_ptr;
    in_ready_o  = (level_o != (AW+1)'(DEPTH));
    out_valid_o = (level_o != '0);
    out_data_o  = mem[rd_ptr[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; contents are only read behind valid
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : rcs_fifo

module rcs_top
  import rcs_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Card backplane lines
  output logic                      card_clk_o,
  output logic                      relay_serial_out_o,
  input  wire logic                 card_ident_serial_in_i,
  output logic      [NUM_CARDS-1:0] card_select_n_o,
  output logic                      ident_address_clear_o,
  output logic                      ident_address_advance_n_o,
  output logic                      latch_strobe_o,
  // Local driver stage
  output logic                      driver_output_enable_n_o,
  output logic      [7:0]           relay_drive_n_o
);

  // Decode a register offset; ident byte answers across its window
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (ofs == OFS_IDENT) ? ((adr & IDENT_MASK) == OFS_IDENT)
                             : (adr == ofs);
  endfunction : hit

  // Bus and register state
  logic       ack;
  logic [31:0] rdata;
  logic [7:0] card_sel;
  logic       addr_clr;
  logic       addr_adv_n;
  logic       latch;
  logic [7:0] ident_byte;
  logic       ident_valid;
  logic       next_ack;
  logic [31:0] next_rdata;
  logic [7:0] next_card_sel;
  logic       next_addr_clr;
  logic       next_addr_adv_n;
  logic       next_latch;
  logic [7:0] next_ident_byte;
  logic       next_ident_valid;

  // FIFO wiring
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [4:0] fifo_level;

  // Sequencer state
  rcs_state_t state;
  rcs_state_t next_state;
  logic [4:0] phase_cnt;
  logic       bus_phase;
  logic [7:0] bit_cnt;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic       card_clk;
  logic       first_fall;
  logic [4:0] next_phase_cnt;
  logic       next_bus_phase;
  logic [7:0] next_bit_cnt;
  logic [7:0] next_tx_sh;
  logic [7:0] next_rx_sh;
  logic       next_card_clk;
  logic       next_first_fall;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       burst_done;

  // Ident input synchroniser and filter
  logic       id_s1;
  logic       id_s2;
  logic       id_s3;
  logic       id_in;
  logic       next_id_in;

  // Local driver chain
  logic [7:0] chain;
  logic [7:0] drv_latch;
  logic       oen_n;
  logic       latch_d;
  logic [7:0] next_chain;
  logic [7:0] next_drv_latch;
  logic       next_oen_n;

  logic bus_req;
  logic relay_wr;

  rcs_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (wb_dat_i[7:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // Bus decode; a relay write waits for FIFO room before it is acked
  always_comb begin
    bus_req          = wb_cyc_i && wb_stb_i && !ack;
    relay_wr         = bus_req && wb_we_i && hit(wb_adr_i, OFS_RELAY)
                       && wb_sel_i[0];
    fifo_in_valid    = relay_wr;
    next_ack         = bus_req && !(relay_wr && !fifo_in_ready);
    next_rdata       = rdata;
    next_card_sel    = card_sel;
    next_addr_clr    = addr_clr;
    next_addr_adv_n  = addr_adv_n;
    next_latch       = latch;
    // R7 card ident byte kept for software
    next_ident_byte  = burst_done ? rx_sh : ident_byte;
    next_ident_valid = ident_valid;
    if (next_ack && wb_we_i && hit(wb_adr_i, OFS_CTRL)) begin
      if (wb_sel_i[0]) begin
        next_card_sel = wb_dat_i[CTRL_SEL_LSB +: NUM_CARDS];
      end
      if (wb_sel_i[1]) begin
        next_addr_clr   = wb_dat_i[CTRL_CLR_BIT];
        next_addr_adv_n = wb_dat_i[CTRL_ADV_BIT];
        next_latch      = wb_dat_i[CTRL_LAT_BIT];
      end
    end
    if (next_ack && !wb_we_i) begin
      next_rdata = 32'h0000_0000;
      if (hit(wb_adr_i, OFS_RELAY)) begin
        next_rdata[4:0] = fifo_level;
      end else if (hit(wb_adr_i, OFS_CTRL)) begin
        next_rdata[CTRL_SEL_LSB +: NUM_CARDS] = card_sel;
        next_rdata[CTRL_CLR_BIT] = addr_clr;
        next_rdata[CTRL_ADV_BIT] = addr_adv_n;
        next_rdata[CTRL_LAT_BIT] = latch;
      end else if (hit(wb_adr_i, OFS_STATUS)) begin
        next_rdata[ST_ACT_BIT]   = bit_cnt[7];
        next_rdata[ST_EMPTY_BIT] = !fifo_out_valid;
        next_rdata[ST_FULL_BIT]  = !fifo_in_ready;
        next_rdata[ST_IDV_BIT]   = ident_valid;
        next_rdata[ST_OEN_BIT]   = oen_n;
        next_rdata[ST_LVL_LSB +: 5] = fifo_level;
      end else if (hit(wb_adr_i, OFS_IDENT)) begin
        // R14 ident byte
        next_rdata[7:0] = ident_byte;
        next_ident_valid = 1'b0;
      end
    end
    // A new byte arriving beats the read that clears the flag
    if (burst_done) begin
      next_ident_valid = 1'b1;
    end
  end

  // Register bank
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack         <= 1'b0;
      rdata       <= 32'h0000_0000;
      card_sel    <= SEL_RESET;
      addr_clr    <= 1'b0;
      addr_adv_n  <= 1'b1;
      latch       <= 1'b0;
      ident_byte  <= 8'h00;
      ident_valid <= 1'b0;
    end else begin
      ack         <= next_ack;
      rdata       <= next_rdata;
      card_sel    <= next_card_sel;
      addr_clr    <= next_addr_clr;
      addr_adv_n  <= next_addr_adv_n;
      latch       <= next_latch;
      ident_byte  <= next_ident_byte;
      ident_valid <= next_ident_valid;
    end
  end

  // Ident input: three stages, a change counts once stages two and three agree
  always_comb begin
    next_id_in = (id_s2 == id_s3) ? id_s3 : id_in;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_s1 <= 1'b0;
      id_s2 <= 1'b0;
      id_s3 <= 1'b0;
      id_in <= 1'b0;
    end else begin
      id_s1 <= card_ident_serial_in_i;
      id_s2 <= id_s1;
      id_s3 <= id_s2;
      id_in <= next_id_in;
    end
  end

  // Card clock sequencer; the bus phase clock runs free so bursts stay
  // in step with it, at the cost of up to one period of start latency
  always_comb begin
    tick            = (phase_cnt == HALF_LAST);
    rise            = tick && !bus_phase;
    fall            = tick && bus_phase;
    next_state      = state;
    // R1 bus phase clock
    next_phase_cnt  = tick ? 5'h00 : phase_cnt + 5'h01;
    next_bus_phase  = tick ? !bus_phase : bus_phase;
    next_bit_cnt    = bit_cnt;
    next_tx_sh      = tx_sh;
    next_rx_sh      = rx_sh;
    next_card_clk   = 1'b0;
    next_first_fall = first_fall;
    fifo_out_ready  = 1'b0;
    burst_done      = 1'b0;
    case (state)
      RCS_IDLE: begin
        if (fifo_out_valid) begin
          // R2 load and preset
          fifo_out_ready  = 1'b1;
          next_tx_sh      = fifo_out_data;
          next_bit_cnt    = CNT_PRESET;
          next_first_fall = 1'b1;
          next_state      = RCS_ALIGN;
        end
      end
      RCS_ALIGN, RCS_LOW: begin
        if (rise) begin
          // R3 gate clock out while active
          if (bit_cnt[7]) begin
            next_card_clk = 1'b1;
            // R19 sample ident on rising edge
            next_rx_sh = {rx_sh[6:0], id_in};
            next_state = RCS_HIGH;
          end else begin
            // R12 full ident byte captured
            burst_done = 1'b1;
            next_state = RCS_IDLE;
          end
        end
      end
      RCS_HIGH: begin
        next_card_clk = !fall;
        if (fall) begin
          // R4 count pulse
          next_bit_cnt = {bit_cnt[6:0], 1'b0};
          // R5 inverted clock shifts after first cycle
          if (!first_fall) begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
          end
          next_first_fall = 1'b0;
          next_state      = RCS_LOW;
        end
      end
      default: begin
        next_state = RCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= RCS_IDLE;
      phase_cnt  <= 5'h00;
      bus_phase  <= 1'b0;
      bit_cnt    <= 8'h00;
      tx_sh      <= 8'h00;
      rx_sh      <= 8'h00;
      card_clk   <= 1'b0;
      first_fall <= 1'b0;
    end else begin
      state      <= next_state;
      phase_cnt  <= next_phase_cnt;
      bus_phase  <= next_bus_phase;
      bit_cnt    <= next_bit_cnt;
      tx_sh      <= next_tx_sh;
      rx_sh      <= next_rx_sh;
      card_clk   <= next_card_clk;
      first_fall <= next_first_fall;
    end
  end

  // Local driver chain and safeguard
  always_comb begin
    next_chain     = chain;
    next_drv_latch = drv_latch;
    next_oen_n     = oen_n;
    // R6 stages share clock, data flows stage to stage
    if (rise && bit_cnt[7] && state != RCS_IDLE) begin
      next_chain = {chain[6:0], tx_sh[7]};
    end
    // R15 R16 latch regardless of card select
    if (latch) begin
      next_drv_latch = chain;
    end
    // R17 first falling latch enables outputs
    if (latch_d && !latch) begin
      next_oen_n = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain     <= 8'h00;
      drv_latch <= 8'h00;
      oen_n     <= 1'b1;
      latch_d   <= 1'b0;
    end else begin
      chain     <= next_chain;
      drv_latch <= next_drv_latch;
      oen_n     <= next_oen_n;
      latch_d   <= latch;
    end
  end

  // Outputs, each straight from a flip-flop
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      relay_drive_n_o <= 8'hff;
    end else begin
      // R18 low energizes; disabled drivers stay high
      relay_drive_n_o <= next_oen_n ? 8'hff : ~next_drv_latch;
    end
  end

  // R8 R9 R10 select, clear and advance lines come from control bits
  assign card_select_n_o           = card_sel;
  assign ident_address_clear_o     = addr_clr;
  assign ident_address_advance_n_o = addr_adv_n;
  assign latch_strobe_o            = latch;
  assign card_clk_o                = card_clk;
  assign relay_serial_out_o        = tx_sh[7];
  assign driver_output_enable_n_o  = oen_n;
  assign wb_dat_o                  = rdata;
  assign wb_ack_o                  = ack;

endmodule : rcs_top

// file: tb/rcs_card_model.sv
// Behavioural plug-in card: ident memory, address counter, shifter
module rcs_card_model (
  // Backplane lines
  input  wire logic card_clk_i,
  input  wire logic sel_n_i,
  input  wire logic clear_i,
  input  wire logic advance_n_i,
  output logic      ident_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int         addr = 0;
  logic [7:0] sh = 8'h00;
  initial ident_o = 1'b0;
  // memory content is an arbitrary pattern of the address
  function automatic logic [7:0] mem(input int a);
    return 8'((a * 29) ^ 90);
  endfunction : mem
  // clear sets the address counter to zero
  always @(posedge clear_i) addr = 0;
  // advance steps the counter and loads the shifter
  always @(negedge advance_n_i) begin
    addr = (addr + 1) % 4096;
    sh = mem(addr);
  end
  // shift on the card clock fall, so the rise sees a settled bit
  always @(negedge card_clk_i) begin
    if (advance_n_i) sh = {sh[6:0], ~sh[0]};
  end
  // unselected card releases the line: show a toggling level
  always @(sel_n_i, sh) begin
    if (sel_n_i === 1'b0) ident_o = sh[7];
    else ident_o = ~ident_o;
  end
endmodule : rcs_card_model

// file: tb/rcs_properties.sv
// Port-level checks of the relay card serial interface
module rcs_properties
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 rst_n_i,
  // Register bus
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  // Card lines
  input wire logic                 card_clk_o,
  input wire logic                 relay_serial_out_o,
  input wire logic [NUM_CARDS-1:0] card_select_n_o,
  input wire logic                 ident_address_clear_o,
  input wire logic                 ident_address_advance_n_o,
  input wire logic                 latch_strobe_o,
  input wire logic                 driver_output_enable_n_o,
  input wire logic [7:0]           relay_drive_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] low_run;
  logic [3:0] rises;
  logic       clk_q;
  logic [3:0] next_low_run;
  logic [3:0] next_rises;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A low run longer than a half period ends a burst
  always_comb begin
    next_low_run = card_clk_o ? 4'h0 : low_run + {3'h0, low_run != 4'hf};
    next_rises = (low_run >= 4'hc) ? 4'h0 : rises;
    if (card_clk_o && !clk_q) begin
      next_rises = next_rises + 4'h1;
    end
  end
  // Burst bookkeeping registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_run <= 4'h0;
      rises <= 4'h0;
      clk_q <= 1'b0;
    end else begin
      low_run <= next_low_run;
      rises <= next_rises;
      clk_q <= card_clk_o;
    end
  end
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack too long");
  a_ack_has_req:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("Ack without request");
  a_pulse_high:
    assert property ($rose(card_clk_o) |->
      card_clk_o[*8] ##1 card_clk_o[*3] ##1 !card_clk_o)
    else $error("Card clock high time wrong");
  a_pulse_low:
    assert property ($fell(card_clk_o) && rises != 4'h8 |->
      !card_clk_o[*8] ##1 !card_clk_o[*3] ##1 card_clk_o)
    else $error("Card clock low time wrong");
  a_burst_eight:
    assert property (low_run == 4'hc |-> rises == 4'h8 || rises == 4'h0)
    else $error("Burst not eight pulses");
  a_burst_max:
    assert property (rises <= 4'h8) else $error("Too many pulses");
  a_data_steady:
    assert property (card_clk_o && $past(card_clk_o) |->
      $stable(relay_serial_out_o)) else $error("Data moved while high");
  a_first_hold:
    assert property ($fell(card_clk_o) && rises == 4'h1 |->
      $stable(relay_serial_out_o)) else $error("Shift on first fall");
  a_ctrl_write:
    assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL &&
      wb_sel_i[1:0] == 2'h3 |-> card_select_n_o == wb_dat_i[7:0] &&
      ident_address_clear_o == wb_dat_i[CTRL_CLR_BIT] &&
      ident_address_advance_n_o == wb_dat_i[CTRL_ADV_BIT] &&
      latch_strobe_o == wb_dat_i[CTRL_LAT_BIT])
    else $error("Control lines not updated");
  a_oen_sticky:
    assert property (!driver_output_enable_n_o |=> !driver_output_enable_n_o)
    else $error("Drivers disabled again");
  a_oen_cause:
    assert property ($fell(driver_output_enable_n_o) |-> !latch_strobe_o &&
      ($past(latch_strobe_o) || $past(latch_strobe_o, 2)))
    else $error("Drivers enabled without latch fall");
  a_drive_off:
    assert property (driver_output_enable_n_o |-> relay_drive_n_o == 8'hff)
    else $error("Relay driven while disabled");
endmodule : rcs_properties

bind rcs_top rcs_properties i_props (.*);

// file: tb/rcs_top_test.sv
// Self-checking bench for the relay card serial interface
module rcs_top_test
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  lanes = 4'hf;
  logic [31:0] rdat;
  logic        ack;
  logic        cclk;
  logic        tx_bit;
  logic        id_bit;
  logic [7:0]  sel_n;
  logic        clr;
  logic        adv_n;
  logic        latch;
  logic        oen_n;
  logic [7:0]  drive_n;
  int          fail_count = 0;
  int          tests_run = 0;
  int          tx_q[$];
  logic        bits[$];
  logic [7:0]  chain = 8'h00;
  logic        pclk = 1'b0;
  logic [31:0] q;
  logic [7:0]  held;
  int          e;
  logic [7:0]  g;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  rcs_top i_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .card_clk_o(cclk),
    .relay_serial_out_o(tx_bit), .card_ident_serial_in_i(id_bit),
    .card_select_n_o(sel_n), .ident_address_clear_o(clr),
    .ident_address_advance_n_o(adv_n), .latch_strobe_o(latch),
    .driver_output_enable_n_o(oen_n), .relay_drive_n_o(drive_n)
  );

  rcs_card_model i_card (
    .card_clk_i(cclk), .sel_n_i(sel_n[0]), .clear_i(clr),
    .advance_n_i(adv_n), .ident_o(id_bit)
  );

  // Closing verdict
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // Classic single cycle; a full queue may hold ack back for a while
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 1000);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 1000) begin
      fail_count++;
      report_and_stop();
    end
  endtask : bus

  task automatic send(input int b);
    tx_q.push_back(b);
    bus(1'b1, OFS_RELAY, 32'(b), q);
  endtask : send

  // Poll one status bit under a bound
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_st

  // Reference: bit 7 shows twice, bit 0 never leaves
  always @(posedge clk) begin
    if (cclk === 1'b1 && pclk === 1'b0) begin
      bits.push_back(tx_bit);
      chain = {chain[6:0], tx_bit};
    end
    pclk = cclk;
    if (bits.size() == 8) begin
      g = 8'h00;
      foreach (bits[i]) g = {g[6:0], bits[i]};
      bits.delete();
      e = (tx_q.size() > 0) ? tx_q.pop_front() : -1;
      chk(g, {e[7], e[7:1]});
    end
  end

  initial begin
    void'($urandom(54419));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped place, drivers off
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q[10:0], 11'h2ff);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[4:0], 5'h12);
    bus(1'b1, 8'h40, 32'hffffffff, q);
    bus(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    chk({oen_n, drive_n}, 9'h1ff);
    // Ident read of card 0: clear once, then advance and shift
    bus(1'b1, OFS_CTRL, 32'h2fe, q);
    bus(1'b1, OFS_CTRL, 32'h3fe, q);
    chk(clr, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h2fe, q);
    chk(clr, 1'b0);
    for (int loc = 1; loc < 4; loc++) begin
      bus(1'b1, OFS_CTRL, 32'h0fe, q);
      bus(1'b1, OFS_CTRL, 32'h2fe, q);
      send($urandom_range(255));
      wait_st(ST_IDV_BIT, 1'b1);
      bus(1'b0, 8'(OFS_IDENT + loc * 5), 32'h0, q);
      chk(q[7:0], 8'((loc * 29) ^ 90));
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk(q[ST_IDV_BIT], 1'b0);
    end
    wait_st(ST_ACT_BIT, 1'b0);
    // Latch with every card deselected
    bus(1'b1, OFS_CTRL, 32'h6ff, q);
    bus(1'b1, OFS_CTRL, 32'h2ff, q);
    repeat (2) @(posedge clk);
    chk({oen_n, drive_n}, {1'b0, ~chain});
    held = drive_n;
    // Overfill the queue: the last write waits for a slot
    repeat (FIFO_DEPTH + 2) send($urandom_range(255));
    bus(1'b0, OFS_RELAY, 32'h0, q);
    chk(q[4:0], 5'(FIFO_DEPTH));
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[ST_FULL_BIT], 1'b1);
    wait_st(ST_EMPTY_BIT, 1'b1);
    wait_st(ST_ACT_BIT, 1'b0);
    repeat (30) @(posedge clk);
    chk(tx_q.size(), 0);
    chk(drive_n, held);
    // Byte lanes gate the relay push and the control fields
    lanes = 4'he;
    bus(1'b1, OFS_RELAY, 32'h5a, q);
    lanes = 4'h1;
    bus(1'b1, OFS_CTRL, 32'h755, q);
    lanes = 4'hf;
    bus(1'b0, OFS_RELAY, 32'h0, q);
    chk(q[4:0], 5'h00);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q[10:0], 11'h255);
    chk(drive_n, held);
    report_and_stop();
  end
endmodule : rcs_top_test
